//--- rtl/iowdt_defines.svh
/*
 constants for the io port watchdog: port address, interval limits, tick timing.
 assumes a 200 MHz mclk_i and an isa style i/o space of 16 address bits.
*/
`ifndef IOWDT_DEFINES_SVH
`define IOWDT_DEFINES_SVH

// register map
`define IOWDT_INTERVAL_ADDR 16'h0443
`define IOWDT_INTERVAL_RESET 8'h00
// interval field and limits
`define IOWDT_INTERVAL_MSB 5
`define IOWDT_INTERVAL_MIN 6'h01
`define IOWDT_INTERVAL_MAX 6'h3f
// host command register space
`define IOWDT_CMD_CTRL 4'h0
`define IOWDT_CMD_STATUS 4'h4
`define IOWDT_CMD_MASK 4'h8
// ctrl bits
`define IOWDT_CTRL_IRQ_MODE 0
// status bits
`define IOWDT_ST_EXPIRED 0
`define IOWDT_ST_READ_DONE 1
// one second tick: period in ns and clock period in ns
`define IOWDT_TICK_NS 1000000000
`define IOWDT_CLK_NS 5
`define IOWDT_TICK_CYCLES (`IOWDT_TICK_NS / `IOWDT_CLK_NS)

`endif

//--- rtl/iowdt_pkg.sv
/*
 types shared by both ends of the io port watchdog.
 assumes iowdt_defines.svh is available for the numeric constants.
*/
package iowdt_pkg;
   // expiry action chosen by the board
   typedef enum logic {
      IOWDT_ACT_RESET = 1'b0,
      IOWDT_ACT_IRQ = 1'b1
   } iowdt_action_t;

   // host access sequencer states
   typedef enum logic [1:0] {
      IOWDT_H_IDLE = 2'b00,
      IOWDT_H_WAIT = 2'b01
   } iowdt_hstate_t;
endpackage : iowdt_pkg

//--- rtl/iowdt_if.sv
/*
 isa style i/o cycle carrier between host and watchdog.
 assumes one clock mclk_i shared by both ends; data lines split per direction.
*/
interface iowdt_if;
   logic [15:0] io_addr;
   logic [7:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_rdata;
   logic cpu_reset;
   logic irq;

   modport dev (input io_addr, io_wdata, io_wr, io_rd, output io_rdata, cpu_reset, irq);
   modport host (output io_addr, io_wdata, io_wr, io_rd, input io_rdata, cpu_reset, irq);
endinterface : iowdt_if

//--- rtl/iowdt_device.sv
/*
 watchdog end: one i/o port, one second time base, countdown and expiry action.
 the port takes a byte; its low six bits are the interval in seconds.
 a nonzero write loads and starts, a later write reloads, a zero write or a read parks the timer.
 on the last tick the strap picks a cpu reset pulse or an interrupt level.
 the read back byte is the seconds left, upper bits zero.
 the interval is exact to the clock: a load restarts the second.
 the port has no other fields and no other address.
 limitations: the upper two bits of a written byte are ignored.
 limitations: the countdown is one shot; after expiry a new write re-arms it.
 assumes single-cycle strobes from the host and a synchronous action_sel_i strap.
 assumes action_sel_i is steady while the timer runs.
 assumes io_wr and io_rd are never high together.
 assumes the host holds the address beside each strobe for its one cycle.
 assumes mclk_i at 200 MHz, so TICK_CYCLES clocks make one second.
 assumes the board stretches the reset pulse if the cpu needs a longer one.
*/
// The plain strobed port was chosen for this implementation.
`include "iowdt_defines.svh"
module iowdt_device
   import iowdt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `IOWDT_TICK_CYCLES
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // board strap: expiry action
   input wire logic action_sel_i,
   // host side
   iowdt_if.dev bus
);
   // port decode
   logic wr_hit;
   logic rd_hit;
   logic access;

   // one second time base
   logic [27:0] prescale;
   logic [27:0] next_prescale;
   logic tick;

   // countdown state
   logic enabled;
   logic next_enabled;
   logic [5:0] count;
   logic [5:0] next_count;
   logic expire;

   // expiry outputs
   logic cpu_reset;
   logic next_cpu_reset;
   logic irq;
   logic next_irq;
   iowdt_action_t action;

   // read back
   logic [7:0] rdata;
   logic [7:0] next_rdata;

   // port decode: only the watchdog port is seen, other i/o cycles pass by
   // the full 16 bit address is compared so aliases of the port stay quiet
   assign wr_hit = bus.io_wr && (bus.io_addr == `IOWDT_INTERVAL_ADDR);
   assign rd_hit = bus.io_rd && (bus.io_addr == `IOWDT_INTERVAL_ADDR);
   assign access = wr_hit || rd_hit;

   // strap level taken as the action code
   // a change of strap takes effect on the next expiry
   assign action = iowdt_action_t'(action_sel_i);

   // prescaler next value: counts clocks within the current second
   // a load restarts the second, so the first unit is a full one
   // and a refresh never lands a tick a few cycles after it
   always_comb begin
      next_prescale = prescale + 28'h0000001;
      // restart on a load, wrap at the end of a second
      if (wr_hit) begin
         next_prescale = 28'h0000000;
      end else if (tick) begin
         next_prescale = 28'h0000000;
      end
   end

   // tick: one-cycle enable at the last clock of each second
   // tick and expire are internal enables, never outputs
   assign tick = (prescale == 28'(TICK_CYCLES - 1));

   // prescaler register
   // runs even while parked; harmless since a load restarts it
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prescale <= 28'h0000000;
      end else begin
         prescale <= next_prescale;
      end
   end

   // expiry: the tick that ends the last second of the interval
   // a port access in the same cycle wins, so a refresh on the
   // very last clock still saves the system
   assign expire = enabled
      && tick
      && (count == `IOWDT_INTERVAL_MIN)
      && !access;

   // countdown next value
   // count holds the seconds left, including the one running now
   always_comb begin
      next_enabled = enabled;
      next_count = count;
      if (wr_hit) begin
         // a rewrite reloads the count from the new value
         next_count = bus.io_wdata[`IOWDT_INTERVAL_MSB:0];
         // zero lies outside the interval range and parks the timer
         next_enabled = (bus.io_wdata[`IOWDT_INTERVAL_MSB:0] != 6'h00);
      end else if (rd_hit) begin
         // a read disarms but keeps the count for read back
         next_enabled = 1'b0;
      end else if (expire) begin
         // one shot: parked until software writes again
         next_enabled = 1'b0;
         next_count = 6'h00;
      end else if (enabled && tick) begin
         // one second gone
         next_count = count - 6'h01;
      end
   end

   // countdown register, parked after reset
   // count starts at zero so a read before any write returns zero
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         enabled <= 1'b0;
         count <= 6'h00;
      end else begin
         enabled <= next_enabled;
         count <= next_count;
      end
   end

   // expiry action next value
   // cpu reset is a one-cycle pulse; the board stretches it if it must
   // irq is a level so a slow handler cannot miss it
   // any port access drops the irq, which doubles as its acknowledge
   always_comb begin
      next_cpu_reset = 1'b0;
      next_irq = irq;
      if (access) begin
         next_irq = 1'b0;
      end else if (expire) begin
         // the strap picks the action
         unique case (action)
            IOWDT_ACT_IRQ: begin
               next_irq = 1'b1;
            end
            IOWDT_ACT_RESET: begin
               next_cpu_reset = 1'b1;
            end
         endcase
      end
   end

   // expiry action register
   // both cleared by reset so no false action after power-up
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cpu_reset <= 1'b0;
         irq <= 1'b0;
      end else begin
         cpu_reset <= next_cpu_reset;
         irq <= next_irq;
      end
   end

   // read back next value: the seconds left at the moment of the read
   // held until the next read, so the host may take it a cycle late
   always_comb begin
      next_rdata = rdata;
      // only a read of the port samples the count
      if (rd_hit) begin
         next_rdata = {2'b00, count};
      end
   end

   // read back register
   // zero until the first read
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata <= `IOWDT_INTERVAL_RESET;
      end else begin
         rdata <= next_rdata;
      end
   end

   // outputs straight from flip-flops
   // no logic between these flops and the link
   assign bus.io_rdata = rdata;
   assign bus.cpu_reset = cpu_reset;
   assign bus.irq = irq;
endmodule : iowdt_device

//--- rtl/iowdt_host.sv
/*
 host end: turns software commands into i/o cycles to the watchdog port.
 assumes software uses the plain command port; data read one cycle after strobe.
*/
`include "iowdt_defines.svh"
module iowdt_host
   import iowdt_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // software command port
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // interrupt and board reset request
   output logic irq_o,
   output logic cpu_reset_o,
   // link
   iowdt_if.host bus
);
   logic [15:0] io_addr, next_io_addr;
   logic [7:0] io_wdata, next_io_wdata;
   logic io_wr, next_io_wr;
   logic io_rd, next_io_rd;
   logic [1:0] status, next_status;
   logic [1:0] mask, next_mask;
   logic [7:0] last_read, next_last_read;
   logic [31:0] rdata, next_rdata;
   iowdt_hstate_t state, next_state;
   logic [1:0] ev;

   assign ev[`IOWDT_ST_EXPIRED] = bus.irq | bus.cpu_reset;
   assign ev[`IOWDT_ST_READ_DONE] = (state == IOWDT_H_WAIT);

   // command decode, i/o cycle issue, sticky status
   always_comb begin
      next_io_addr = io_addr;
      next_io_wdata = io_wdata;
      next_io_wr = 1'b0;
      next_io_rd = 1'b0;
      next_mask = mask;
      next_last_read = last_read;
      next_rdata = 32'h00000000;
      next_state = io_rd ? IOWDT_H_WAIT : IOWDT_H_IDLE; // port answers a cycle after io_rd
      next_status = status;
      if (wr_i && addr_i == `IOWDT_CMD_STATUS) begin
         next_status = status & ~wdata_i[1:0];
      end
      next_status = next_status | ev; // set beats clear
      if (state == IOWDT_H_WAIT) begin
         next_last_read = bus.io_rdata;
      end
      if (wr_i) begin
         unique case (addr_i)
            `IOWDT_CMD_CTRL: begin
               next_io_addr = `IOWDT_INTERVAL_ADDR;
               next_io_wdata = {2'b00, wdata_i[`IOWDT_INTERVAL_MSB:0]};
               next_io_wr = 1'b1;
            end
            `IOWDT_CMD_MASK: next_mask = wdata_i[1:0];
            default: ;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            `IOWDT_CMD_CTRL: begin
               next_io_addr = `IOWDT_INTERVAL_ADDR;
               next_io_rd = 1'b1;
               next_rdata = {24'h000000, last_read};
            end
            `IOWDT_CMD_STATUS: next_rdata = {30'h00000000, status};
            `IOWDT_CMD_MASK: next_rdata = {30'h00000000, mask};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // register host state
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         io_addr <= 16'h0000;
         io_wdata <= 8'h00;
         io_wr <= 1'b0;
         io_rd <= 1'b0;
         status <= 2'h0;
         mask <= 2'h0;
         last_read <= 8'h00;
         rdata <= 32'h00000000;
         state <= IOWDT_H_IDLE;
      end else begin
         io_addr <= next_io_addr;
         io_wdata <= next_io_wdata;
         io_wr <= next_io_wr;
         io_rd <= next_io_rd;
         status <= next_status;
         mask <= next_mask;
         last_read <= next_last_read;
         rdata <= next_rdata;
         state <= next_state;
      end
   end

   assign bus.io_addr = io_addr;
   assign bus.io_wdata = io_wdata;
   assign bus.io_wr = io_wr;
   assign bus.io_rd = io_rd;
   assign rdata_o = rdata;
   assign irq_o = |(status & mask);
   assign cpu_reset_o = bus.cpu_reset;
endmodule : iowdt_host

//--- sim/iowdt_chk.sv
/*
 checker on the host to watchdog link.
 assumes one clock and a TICK_CYCLES equal to the device's.
*/
module iowdt_chk #(
   parameter int unsigned TICK_CYCLES = 10
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // link signals
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic cpu_reset,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   int lim;
   logic armed;
   logic irq_q;
   logic fire;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // expiry event in either action mode
   assign fire = cpu_reset || (irq && !irq_q);
   // cycles since the last load and where expiry is due
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= 0;
         lim <= 0;
         armed <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq;
         cnt <= cnt + 1;
         if (io_wr) begin
            cnt <= 0;
            lim <= int'(io_wdata[5:0]) * int'(TICK_CYCLES);
            armed <= (io_wdata[5:0] != 6'h00);
         end else if (io_rd || fire) begin
            armed <= 1'b0;
         end
      end
   end
   AST_WR_PORT: assert property (io_wr |-> io_addr == 16'h0443)
      else $error("write off the watchdog port");
   AST_ONE_STROBE: assert property (!(io_wr && io_rd))
      else $error("read and write together");
   AST_ON_TIME: assert property (fire |-> armed && cnt + 2 >= lim && cnt <= lim + 3)
      else $error("expiry at the wrong time or while disabled");
   AST_NOT_LATE: assert property (!(armed && cnt > lim + 3))
      else $error("expiry missing");
   AST_PULSE: assert property (cpu_reset |=> !cpu_reset)
      else $error("reset pulse too long");
   AST_IRQ_HOLD: assert property (irq && !io_wr && !io_rd |=> irq)
      else $error("interrupt dropped early");
   AST_ACCESS_CLR: assert property (io_rd || io_wr |=> !irq)
      else $error("interrupt kept after access");
   AST_QUIET: assert property (io_rd ##1 (!io_wr) [*8] |-> !cpu_reset && !irq)
      else $error("expiry after disable");
endmodule : iowdt_chk

//--- sim/io_port_watchdog_timer_test.sv
/*
 bench: host and watchdog joined, driven through the command port.
 assumes a short TICK_CYCLES and status bit0 set by either expiry action.
*/
module io_port_watchdog_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 10;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic action_sel_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic irq_o;
   logic cpu_reset_o;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int i;
   logic seen;
   iowdt_if bus();
   iowdt_device #(.TICK_CYCLES(TICK)) i_iowdt_device(.mclk_i(mclk_i), .rstn_i(rstn_i),
      .action_sel_i(action_sel_i), .bus(bus));
   iowdt_host i_iowdt_host(.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o), .bus(bus));
   iowdt_chk #(.TICK_CYCLES(TICK)) i_iowdt_chk(.mclk_i(mclk_i), .rstn_i(rstn_i), .io_addr(bus.io_addr),
      .io_wdata(bus.io_wdata), .io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_rdata(bus.io_rdata),
      .cpu_reset(bus.cpu_reset), .irq(bus.irq));
   // clock and hang guard
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         test_done();
      end
   end
   task test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   // read data stand in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o & m, e);
   endtask : rd
   task idle(input int n, input logic e);
      repeat (n) @(posedge mclk_i);
      #1 chk(irq_o, e);
   endtask : idle
   initial begin
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rd(4'h4, 32'hffffffff, 32'h0);
      rd(4'hc, 32'hffffffff, 32'h0);
      wr(4'h8, 32'h1);
      wr(4'h0, 32'h3);
      idle(25, 1'b0);
      idle(12, 1'b1);
      rd(4'h4, 32'h1, 32'h1);
      wr(4'h0, 32'h0);
      wr(4'h4, 32'h1);
      idle(1, 1'b0);
      wr(4'h0, 32'h2);
      idle(15, 1'b0);
      wr(4'h0, 32'h2);
      idle(15, 1'b0);
      idle(12, 1'b1);
      wr(4'h0, 32'h0);
      wr(4'h4, 32'h1);
      wr(4'h0, 32'h1);
      rd(4'h0, 32'hffffffff, 32'h0);
      idle(2, 1'b0);
      rd(4'h0, 32'h3f, 32'h1);
      rd(4'h4, 32'h2, 32'h2);
      idle(40, 1'b0);
      wr(4'h0, 32'h43);
      wr(4'h0, 32'h0);
      idle(40, 1'b0);
      action_sel_i <= 1'b0;
      wr(4'h8, 32'h0);
      wr(4'h0, 32'h1);
      seen = 1'b0;
      for (i = 0; i < 30; i++) begin
         @(posedge mclk_i);
         #1 if (cpu_reset_o === 1'b1) seen = 1'b1;
      end
      chk(seen, 1'b1);
      chk(irq_o, 1'b0);
      wr(4'h8, 32'h1);
      idle(0, 1'b1);
      wr(4'h4, 32'h1);
      idle(0, 1'b0);
      test_done();
   end
endmodule : io_port_watchdog_timer_test
